// file: rtl/tsm_cfg.svh
// constants of the thickness meter setup command interpreter
`ifndef TSM_CFG_SVH
`define TSM_CFG_SVH

`define TSM_CR 8'h0d
`define TSM_LF 8'h0a
`define TSM_SP 8'h20
`define TSM_COMMA 8'h2c
`define TSM_DOT 8'h2e
`define TSM_PLUS 8'h2b
`define TSM_MINUS 8'h2d
`define TSM_CH_0 8'h30
`define TSM_CH_9 8'h39
`define TSM_CH_A 8'h41
`define TSM_CH_F 8'h46
`define TSM_CH_ACK 8'h47
`define TSM_CH_E 8'h45
`define TSM_CH_R 8'h52
`define TSM_TEN 8'h0a
`define TSM_HEX_OFS 8'h37

`define TSM_NUM_LEN 8
`define TSM_FIELD_LEN 12
`define TSM_MAX_FIELDS 4
`define TSM_SLOTS 6
`define TSM_COEFFS 4
`define TSM_REPLY_LEN 7

`define TSM_NUM_MAX 4'h8
`define TSM_COEF_MAX 4'hc
`define TSM_FIELD_FULL 4'hc
`define TSM_LAST_FIELD 2'h3
`define TSM_MNEM_LEN 2'h3
`define TSM_PROBE_MAX 4'hc
`define TSM_SLOT_FIRST 4'h6
`define TSM_SLOT_LAST 4'hb
`define TSM_SLOT_NUM_MIN 4'h1
`define TSM_SLOT_NUM_MAX 4'h6
`define TSM_COEF_SEL_MAX 4'h3
`define TSM_AVG_MIN 7'h01
`define TSM_AVG_MAX 7'h40
`define TSM_DIG_0 4'h0
`define TSM_DIG_1 4'h1
`define TSM_DIG_2 4'h2
`define TSM_DIG_3 4'h3
`define TSM_INCH_FIRST 4'h2
`define TSM_ACK_LEN 3'h3
`define TSM_ERR_LEN 3'h7

`define TSM_ERR_NONE 8'h00
`define TSM_ERR_UNKNOWN 8'h15
`define TSM_ERR_FORMAT 8'h16
`define TSM_ERR_RANGE 8'h17
`define TSM_ERR_NOT_ALLOWED 8'h18
`define TSM_ERR_DUP_SLOT 8'h19

`define TSM_MN_DISP_TYPE 24'h445453
`define TSM_MN_DISP_UNIT 24'h554e53
`define TSM_MN_REF_PIECE 24'h4d4153
`define TSM_MN_SPACING 24'h474153
`define TSM_MN_INS_GAP 24'h524553
`define TSM_MN_PERMIT 24'h524453
`define TSM_MN_GAP_SEL 24'h475053
`define TSM_MN_PROBE 24'h535453
`define TSM_MN_CORR_REG 24'h535353
`define TSM_MN_COEFF 24'h534353
`define TSM_MN_AVERAGE 24'h414e53
`define TSM_MN_FAN 24'h464653
`define TSM_MN_SPAN 24'h414653
`define TSM_MN_ZERO 24'h415a53
`define TSM_MN_REPLY 24'h415253

`define TSM_RST_UNIT 2'h0
`define TSM_RST_PROBE 4'h1
`define TSM_RST_AVG 7'h01
`define TSM_RST_FAN 1'b1
`define TSM_RST_ANSWER 1'b1

`endif

// file: rtl/tsm_pkg.sv
// types of the thickness meter setup command interpreter
`include "tsm_cfg.svh"
package tsm_pkg;

  typedef logic [7:0] tsm_char_t;
  typedef logic [`TSM_NUM_LEN-1:0][7:0] tsm_text_t;
  typedef logic [`TSM_FIELD_LEN-1:0][7:0] tsm_field_t;

  typedef enum logic [2:0] {
    PH_MNEM = 3'b000,
    PH_ARGS = 3'b001,
    PH_LF = 3'b010,
    PH_SKIP = 3'b011,
    PH_EXEC = 3'b100
  } tsm_ph_t;

  typedef enum logic [3:0] {
    CMD_NONE = 4'b0000,
    CMD_DISP_TYPE = 4'b0001,
    CMD_DISP_UNIT = 4'b0010,
    CMD_REF_PIECE = 4'b0011,
    CMD_SPACING = 4'b0100,
    CMD_INS_GAP = 4'b0101,
    CMD_PERMIT = 4'b0110,
    CMD_GAP_SEL = 4'b0111,
    CMD_PROBE = 4'b1000,
    CMD_CORR_REG = 4'b1001,
    CMD_COEFF = 4'b1010,
    CMD_AVERAGE = 4'b1011,
    CMD_FAN = 4'b1100,
    CMD_SPAN = 4'b1101,
    CMD_ZERO = 4'b1110,
    CMD_REPLY = 4'b1111
  } tsm_cmd_t;

  typedef struct packed {
    logic disp_dual;
    logic [1:0] disp_unit;
    logic [3:0] ref_sel;
    tsm_text_t ref_thick;
    tsm_text_t sensor_gap;
    tsm_text_t ins_ref_gap;
    logic [3:0] permit_sel;
    tsm_text_t permit;
    logic ins_gap_b;
    logic [3:0] probe_a;
    logic [3:0] probe_b;
    logic [`TSM_SLOTS-1:0] corr_chan;
    logic [`TSM_SLOTS-1:0][`TSM_NUM_LEN*8-1:0] corr_model;
    logic [`TSM_SLOTS-1:0][`TSM_NUM_LEN*8-1:0] corr_serial;
    logic [`TSM_SLOTS-1:0][`TSM_COEFFS-1:0][`TSM_FIELD_LEN*8-1:0] coeff;
    logic [6:0] avg_count;
    logic fan_on;
    tsm_text_t span;
    tsm_text_t zero;
    logic answer_on;
  } tsm_setup_t;

  typedef struct packed {
    tsm_ph_t ph;
    logic [2:0][7:0] mnem;
    logic [1:0] mcnt;
    logic has_args;
    logic bad;
    logic [1:0] fidx;
    logic [`TSM_MAX_FIELDS-1:0][3:0] flen;
    logic [`TSM_MAX_FIELDS-1:0][`TSM_FIELD_LEN*8-1:0] fld;
    logic done;
    logic [7:0] last_err;
    tsm_setup_t setup;
  } tsm_rx_state_t;

  typedef struct packed {
    logic [`TSM_REPLY_LEN-1:0][7:0] bytes;
    logic [2:0] left;
  } tsm_tx_state_t;

endpackage

// file: rtl/tsm_reply_tx.sv
// reply serialiser: acknowledge or numbered error, ended by cr lf
`timescale 1ns/1ps
`default_nettype none
`include "tsm_cfg.svh"
module tsm_reply_tx import tsm_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // reply request
  input wire logic start,
  input wire logic [7:0] code,
  output logic busy,
  // byte stream to host
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready
);

  tsm_tx_state_t s_r;
  tsm_tx_state_t s_nxt;
  logic [7:0] tens;
  logic [7:0] ones;

  assign tens = 8'(code / `TSM_TEN + `TSM_CH_0);
  assign ones = 8'(code % `TSM_TEN + `TSM_CH_0);

  always_comb begin
    s_nxt = s_r;
    if (s_r.left != 3'h0 && tx_ready) begin
      s_nxt.bytes = s_r.bytes >> 8;
      s_nxt.left = s_r.left - 3'h1;
    end
    if (start) begin
      if (code == `TSM_ERR_NONE) begin
        s_nxt.bytes = {32'h0, `TSM_LF, `TSM_CR, `TSM_CH_ACK};
        s_nxt.left = `TSM_ACK_LEN;
      end else begin
        s_nxt.bytes = {`TSM_LF, `TSM_CR, ones, tens,
                       `TSM_CH_R, `TSM_CH_R, `TSM_CH_E};
        s_nxt.left = `TSM_ERR_LEN;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = s_r.left != 3'h0;
  assign tx_valid = s_r.left != 3'h0;
  assign tx_data = s_r.bytes[0];

endmodule
`default_nettype wire

// file: rtl/tsm_setup_cmd.sv
// setup command interpreter of a two-sensor thickness meter
`timescale 1ns/1ps
`default_nettype none
`include "tsm_cfg.svh"
module tsm_setup_cmd import tsm_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command bytes from host
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // reply bytes to host
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // unit and corrective-slot options
  input wire logic inch_option,
  input wire logic corr_enable,
  // settings and events
  output tsm_setup_t setup,
  output logic cmd_done,
  output logic [7:0] cmd_err
);

  tsm_rx_state_t s_r;
  tsm_rx_state_t s_nxt;
  logic tx_busy;
  logic reply_start;
  logic [7:0] reply_code;

  function automatic logic is_dig(input logic [7:0] c);
    return c >= `TSM_CH_0 && c <= `TSM_CH_9;
  endfunction

  // {ok, value} of a one-digit decimal field
  function automatic logic [4:0] one_dig(input tsm_field_t f,
                                         input logic [3:0] l);
    logic [7:0] v;
    v = 8'(f[0] - `TSM_CH_0);
    return {l == 4'h1 && is_dig(f[0]), v[3:0]};
  endfunction

  // {ok, value} of a one-digit hexadecimal field
  function automatic logic [4:0] one_hex(input tsm_field_t f,
                                         input logic [3:0] l);
    logic [7:0] v;
    logic hx;
    hx = f[0] >= `TSM_CH_A && f[0] <= `TSM_CH_F;
    v = hx ? 8'(f[0] - `TSM_HEX_OFS) : 8'(f[0] - `TSM_CH_0);
    return {l == 4'h1 && (is_dig(f[0]) || hx), v[3:0]};
  endfunction

  // {ok, value} of a one- or two-digit decimal count
  function automatic logic [7:0] two_dig(input tsm_field_t f,
                                         input logic [3:0] l);
    logic [6:0] d0;
    logic [6:0] d1;
    d0 = 7'(f[0] - `TSM_CH_0);
    d1 = 7'(f[1] - `TSM_CH_0);
    if (l == 4'h1 && is_dig(f[0])) begin
      return {1'b1, d0};
    end
    if (l == 4'h2 && is_dig(f[0]) && is_dig(f[1])) begin
      return {1'b1, 7'(d0 * 7'(`TSM_TEN) + d1)};
    end
    return 8'h00;
  endfunction

  // numeric text: digits, at most one point, leading sign only if sgn is set
  function automatic logic num_ok(input tsm_field_t f,
                                  input logic [3:0] l,
                                  input logic [3:0] maxl,
                                  input logic sgn);
    logic ok;
    logic [3:0] dots;
    logic [3:0] digs;
    ok = l != 4'h0 && l <= maxl;
    dots = 4'h0;
    digs = 4'h0;
    for (int i = 0; i < `TSM_FIELD_LEN; i++) begin
      if (i < int'(l)) begin
        if (is_dig(f[i])) begin
          digs = digs + 4'h1;
        end else if (f[i] == `TSM_DOT) begin
          dots = dots + 4'h1;
        end else if (!(i == 0 && sgn &&
                       (f[i] == `TSM_PLUS || f[i] == `TSM_MINUS))) begin
          ok = 1'b0;
        end
      end
    end
    return ok && dots <= 4'h1 && digs != 4'h0;
  endfunction

  function automatic tsm_cmd_t decode(input logic [23:0] m);
    unique case (m)
      `TSM_MN_DISP_TYPE: return CMD_DISP_TYPE;
      `TSM_MN_DISP_UNIT: return CMD_DISP_UNIT;
      `TSM_MN_REF_PIECE: return CMD_REF_PIECE;
      `TSM_MN_SPACING: return CMD_SPACING;
      `TSM_MN_INS_GAP: return CMD_INS_GAP;
      `TSM_MN_PERMIT: return CMD_PERMIT;
      `TSM_MN_GAP_SEL: return CMD_GAP_SEL;
      `TSM_MN_PROBE: return CMD_PROBE;
      `TSM_MN_CORR_REG: return CMD_CORR_REG;
      `TSM_MN_COEFF: return CMD_COEFF;
      `TSM_MN_AVERAGE: return CMD_AVERAGE;
      `TSM_MN_FAN: return CMD_FAN;
      `TSM_MN_SPAN: return CMD_SPAN;
      `TSM_MN_ZERO: return CMD_ZERO;
      `TSM_MN_REPLY: return CMD_REPLY;
      default: return CMD_NONE;
    endcase
  endfunction

  always_comb begin
    tsm_field_t f0;
    tsm_field_t f1;
    tsm_field_t f2;
    tsm_field_t f3;
    logic [3:0] l0;
    logic [3:0] l1;
    logic [3:0] l2;
    logic [3:0] l3;
    logic [2:0] nargs;
    logic [4:0] a;
    logic [4:0] b;
    logic [7:0] avg;
    logic [3:0] other;
    logic [7:0] err;
    tsm_cmd_t cmd;
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    f0 = s_r.fld[0];
    f1 = s_r.fld[1];
    f2 = s_r.fld[2];
    f3 = s_r.fld[3];
    l0 = s_r.flen[0];
    l1 = s_r.flen[1];
    l2 = s_r.flen[2];
    l3 = s_r.flen[3];
    nargs = s_r.has_args ? 3'(s_r.fidx) + 3'h1 : 3'h0;
    a = one_dig(f0, l0);
    b = one_dig(f1, l1);
    avg = two_dig(f0, l0);
    other = a[3:0] == `TSM_DIG_0 ? s_r.setup.probe_b : s_r.setup.probe_a;
    cmd = decode(s_r.mnem);
    err = `TSM_ERR_NONE;
    reply_start = 1'b0;
    // line assembly
    if (rx_valid && rx_ready) begin
      unique case (s_r.ph)
        PH_MNEM: begin
          if (rx_data == `TSM_CR) begin
            s_nxt.ph = PH_LF;
          end else if (s_r.mcnt == `TSM_MNEM_LEN) begin
            if (rx_data == `TSM_SP) begin
              s_nxt.ph = PH_ARGS;
              s_nxt.has_args = 1'b1;
            end else begin
              s_nxt.bad = 1'b1;
              s_nxt.ph = PH_SKIP;
            end
          end else begin
            s_nxt.mnem = {s_r.mnem[1:0], rx_data};
            s_nxt.mcnt = s_r.mcnt + 2'h1;
          end
        end
        PH_ARGS: begin
          if (rx_data == `TSM_CR) begin
            s_nxt.ph = PH_LF;
          end else if (rx_data == `TSM_COMMA) begin
            if (s_r.fidx == `TSM_LAST_FIELD) begin
              s_nxt.bad = 1'b1;
            end else begin
              s_nxt.fidx = s_r.fidx + 2'h1;
            end
          end else if (s_r.flen[s_r.fidx] == `TSM_FIELD_FULL) begin
            s_nxt.bad = 1'b1;
          end else begin
            s_nxt.fld[s_r.fidx][s_r.flen[s_r.fidx]*8 +: 8] = rx_data;
            s_nxt.flen[s_r.fidx] = s_r.flen[s_r.fidx] + 4'h1;
          end
        end
        PH_LF: begin
          if (rx_data == `TSM_LF) begin
            s_nxt.ph = PH_EXEC;
          end else begin
            s_nxt.bad = 1'b1;
            s_nxt.ph = PH_SKIP;
          end
        end
        PH_SKIP: begin
          if (rx_data == `TSM_LF) begin
            s_nxt.ph = PH_EXEC;
          end
        end
        PH_EXEC: begin
        end
      endcase
    end
    // execution; every setup store below happens only on an accepted line
    if (s_r.ph == PH_EXEC) begin
      if (cmd == CMD_NONE || s_r.mcnt != `TSM_MNEM_LEN) begin
        err = `TSM_ERR_UNKNOWN;
      end else if (s_r.bad) begin
        err = `TSM_ERR_FORMAT;
      end else begin
        unique case (cmd)
          CMD_NONE: err = `TSM_ERR_UNKNOWN;
          CMD_DISP_TYPE: begin
            if (nargs != 3'h1 || !a[4] || a[3:0] > `TSM_DIG_1) begin
              err = `TSM_ERR_RANGE;
            end else begin
              s_nxt.setup.disp_dual = a[0];
            end
          end
          CMD_DISP_UNIT: begin
            if (nargs != 3'h1 || !a[4] || a[3:0] > `TSM_DIG_3) begin
              err = `TSM_ERR_RANGE;
            end else if (inch_option != (a[3:0] >= `TSM_INCH_FIRST)) begin
              err = `TSM_ERR_NOT_ALLOWED;
            end else begin
              s_nxt.setup.disp_unit = a[1:0];
            end
          end
          CMD_REF_PIECE: begin
            if (nargs != 3'h2 || !a[4] ||
                !num_ok(f1, l1, `TSM_NUM_MAX, 1'b0)) begin
              err = `TSM_ERR_RANGE;
            end else begin
              s_nxt.setup.ref_sel = a[3:0];
              s_nxt.setup.ref_thick = f1[`TSM_NUM_LEN-1:0];
            end
          end
          CMD_SPACING, CMD_INS_GAP, CMD_SPAN, CMD_ZERO: begin
            if (nargs != 3'h1 || !num_ok(f0, l0, `TSM_NUM_MAX, 1'b0)) begin
              err = `TSM_ERR_RANGE;
            end else if (cmd == CMD_SPACING) begin
              s_nxt.setup.sensor_gap = f0[`TSM_NUM_LEN-1:0];
            end else if (cmd == CMD_INS_GAP) begin
              s_nxt.setup.ins_ref_gap = f0[`TSM_NUM_LEN-1:0];
            end else if (cmd == CMD_SPAN) begin
              s_nxt.setup.span = f0[`TSM_NUM_LEN-1:0];
            end else begin
              s_nxt.setup.zero = f0[`TSM_NUM_LEN-1:0];
            end
          end
          CMD_PERMIT: begin
            if (nargs != 3'h2 || !a[4] ||
                !num_ok(f1, l1, `TSM_NUM_MAX, 1'b0)) begin
              err = `TSM_ERR_RANGE;
            end else begin
              s_nxt.setup.permit_sel = a[3:0];
              s_nxt.setup.permit = f1[`TSM_NUM_LEN-1:0];
            end
          end
          CMD_GAP_SEL: begin
            if (nargs != 3'h1 || !a[4] || a[3:0] > `TSM_DIG_1) begin
              err = `TSM_ERR_RANGE;
            end else begin
              s_nxt.setup.ins_gap_b = a[0];
            end
          end
          CMD_PROBE: begin
            b = one_hex(f1, l1);
            if (nargs != 3'h2 || !a[4] || a[3:0] > `TSM_DIG_1 ||
                !b[4] || b[3:0] > `TSM_PROBE_MAX) begin
              err = `TSM_ERR_RANGE;
            end else if (b[3:0] >= `TSM_SLOT_FIRST &&
                         b[3:0] <= `TSM_SLOT_LAST && !corr_enable) begin
              err = `TSM_ERR_NOT_ALLOWED;
            end else if (b[3:0] >= `TSM_SLOT_FIRST &&
                         b[3:0] <= `TSM_SLOT_LAST && other == b[3:0]) begin
              err = `TSM_ERR_DUP_SLOT;
            end else if (a[0]) begin
              s_nxt.setup.probe_b = b[3:0];
            end else begin
              s_nxt.setup.probe_a = b[3:0];
            end
          end
          CMD_CORR_REG: begin
            if (nargs != 3'h4 || !a[4] || a[3:0] < `TSM_SLOT_NUM_MIN ||
                a[3:0] > `TSM_SLOT_NUM_MAX || !b[4] ||
                b[3:0] > `TSM_DIG_1 || l2 == 4'h0 || l3 == 4'h0 ||
                l2 > `TSM_NUM_MAX || l3 > `TSM_NUM_MAX) begin
              err = `TSM_ERR_RANGE;
            end else begin
              s_nxt.setup.corr_chan[a[2:0] - 3'h1] = b[0];
              s_nxt.setup.corr_model[a[2:0] - 3'h1] =
                f2[`TSM_NUM_LEN-1:0];
              s_nxt.setup.corr_serial[a[2:0] - 3'h1] =
                f3[`TSM_NUM_LEN-1:0];
            end
          end
          CMD_COEFF: begin
            if (nargs != 3'h3 || !a[4] || a[3:0] < `TSM_SLOT_NUM_MIN ||
                a[3:0] > `TSM_SLOT_NUM_MAX || !b[4] ||
                b[3:0] > `TSM_COEF_SEL_MAX ||
                !num_ok(f2, l2, `TSM_COEF_MAX, 1'b1)) begin
              err = `TSM_ERR_RANGE;
            end else begin
              s_nxt.setup.coeff[a[2:0] - 3'h1][b[1:0]] = f2;
            end
          end
          CMD_AVERAGE: begin
            if (nargs != 3'h1 || !avg[7] || avg[6:0] < `TSM_AVG_MIN ||
                avg[6:0] > `TSM_AVG_MAX) begin
              err = `TSM_ERR_RANGE;
            end else begin
              s_nxt.setup.avg_count = avg[6:0];
            end
          end
          CMD_FAN: begin
            if (nargs != 3'h1 || !a[4] || a[3:0] < `TSM_DIG_1 ||
                a[3:0] > `TSM_DIG_2) begin
              err = `TSM_ERR_RANGE;
            end else begin
              s_nxt.setup.fan_on = a[3:0] == `TSM_DIG_1;
            end
          end
          CMD_REPLY: begin
            if (nargs != 3'h1 || !a[4] || a[3:0] > `TSM_DIG_1) begin
              err = `TSM_ERR_RANGE;
            end else begin
              s_nxt.setup.answer_on = a[3:0] == `TSM_DIG_0;
            end
          end
        endcase
      end
      reply_start = s_nxt.setup.answer_on;
      s_nxt.done = 1'b1;
      s_nxt.last_err = err;
      s_nxt.ph = PH_MNEM;
      s_nxt.mnem = '0;
      s_nxt.mcnt = 2'h0;
      s_nxt.has_args = 1'b0;
      s_nxt.bad = 1'b0;
      s_nxt.fidx = 2'h0;
      s_nxt.flen = '0;
      s_nxt.fld = '0;
    end
    reply_code = err;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.ph <= PH_MNEM;
      s_r.setup.disp_unit <= `TSM_RST_UNIT;
      s_r.setup.probe_a <= `TSM_RST_PROBE;
      s_r.setup.probe_b <= `TSM_RST_PROBE;
      s_r.setup.avg_count <= `TSM_RST_AVG;
      s_r.setup.fan_on <= `TSM_RST_FAN;
      s_r.setup.answer_on <= `TSM_RST_ANSWER;
    end else begin
      s_r <= s_nxt;
    end
  end

  // no new byte while a line executes or a reply is still going out
  assign rx_ready = s_r.ph != PH_EXEC && !tx_busy;
  assign setup = s_r.setup;
  assign cmd_done = s_r.done;
  assign cmd_err = s_r.last_err;

  tsm_reply_tx u_reply (
    .clk(clk),
    .rst(rst),
    .start(reply_start),
    .code(reply_code),
    .busy(tx_busy),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready)
  );

endmodule
`default_nettype wire

// file: verif/tsm_setup_cmd_assertions.sv
// port assertions of the setup command interpreter
`timescale 1ns/1ps
`default_nettype none
module tsm_setup_cmd_assertions import tsm_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command and reply bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  // options, settings, events
  input wire logic inch_option,
  input wire logic corr_enable,
  input wire tsm_setup_t setup,
  input wire logic cmd_done,
  input wire logic [7:0] cmd_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst_vals;
    disable iff (1'b0) rst |=> !tx_valid && !cmd_done && rx_ready &&
      cmd_err == 8'h00 && setup.avg_count == 7'h01 && setup.answer_on;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("outputs not at reset values");
  property p_done_pulse;
    cmd_done |=> !cmd_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("completion pulse too long");
  property p_err_code;
    cmd_err == 8'h00 || (cmd_err >= 8'h15 && cmd_err <= 8'h1e);
  endproperty
  a_err_code: assert property (p_err_code)
    else $error("completion code out of range");
  property p_avg_range;
    setup.avg_count >= 7'h01 && setup.avg_count <= 7'h40;
  endproperty
  a_avg_range: assert property (p_avg_range)
    else $error("average count out of range");
  property p_probe_max;
    setup.probe_a <= 4'hc && setup.probe_b <= 4'hc;
  endproperty
  a_probe_max: assert property (p_probe_max)
    else $error("probe code above c");
  property p_slot_dup;
    setup.probe_a inside {[4'h6:4'hb]} |-> setup.probe_a != setup.probe_b;
  endproperty
  a_slot_dup: assert property (p_slot_dup)
    else $error("same corrective slot on both channels");
  property p_corr_gate;
    cmd_done && $changed(setup.probe_a) &&
      setup.probe_a inside {[4'h6:4'hb]} |-> corr_enable;
  endproperty
  a_corr_gate: assert property (p_corr_gate)
    else $error("corrective slot taken while feature off");
  property p_reject_keep;
    cmd_done && cmd_err != 8'h00 |-> $stable(setup);
  endproperty
  a_reject_keep: assert property (p_reject_keep)
    else $error("rejected line changed settings");
  property p_quiet;
    !cmd_done && !$past(rst) |-> $stable(setup);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("settings changed without a line");
  property p_unit_opt;
    cmd_done && $changed(setup.disp_unit) |->
      setup.disp_unit[1] == inch_option;
  endproperty
  a_unit_opt: assert property (p_unit_opt)
    else $error("unit does not suit inch option");
  property p_reply_gate;
    $rose(tx_valid) |-> cmd_done && setup.answer_on;
  endproperty
  a_reply_gate: assert property (p_reply_gate)
    else $error("reply without line or answer-back off");
  property p_stall_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("reply byte lost under stall");
  property p_rx_block;
    tx_valid |-> !rx_ready;
  endproperty
  a_rx_block: assert property (p_rx_block)
    else $error("command byte offered ready while reply pending");
endmodule
bind tsm_setup_cmd tsm_setup_cmd_assertions i_chk (
  .clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_ready(tx_ready), .inch_option(inch_option),
  .corr_enable(corr_enable), .setup(setup), .cmd_done(cmd_done),
  .cmd_err(cmd_err)
);
`default_nettype wire

// file: verif/tsm_host_model.sv
// host model: sends command lines, collects reply bytes
`timescale 1ns/1ps
`default_nettype none
`include "tsm_cfg.svh"
module tsm_host_model (
  // clock
  input wire logic clk,
  // command bytes
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // reply bytes
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic slow;
  logic [7:0] rq[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
    slow = 1'b0;
  end
  // slow mode stalls every other cycle
  always @(negedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
  always @(posedge clk) begin
    if (tx_valid && tx_ready) rq.push_back(tx_data);
  end
  // byte held until the edge that takes it
  task automatic put(input logic [7:0] b);
    rx_valid = 1'b1;
    rx_data = b;
    while (!rx_ready) @(negedge clk);
    @(negedge clk);
  endtask
  // mnemonic, space and arguments if any, cr lf
  task automatic send(input logic [23:0] mn, input string a);
    put(mn[23:16]);
    put(mn[15:8]);
    put(mn[7:0]);
    if (a.len() > 0) put(`TSM_SP);
    foreach (a[i]) put(a[i]);
    put(`TSM_CR);
    put(`TSM_LF);
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
// testbench of the setup command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "tsm_cfg.svh"
module testbench;
  import tsm_pkg::*;
  logic clk, rst, rx_valid, rx_ready, tx_valid, tx_ready;
  logic inch_option, corr_enable, cmd_done, ok, reply_exp;
  logic [7:0] rx_data, tx_data, cmd_err, ec;
  logic [1:0] eu;
  tsm_setup_t setup;
  int err_count = 0;
  int samples_checked = 0;
  tsm_setup_cmd i_dut (.clk(clk), .rst(rst), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .inch_option(inch_option),
    .corr_enable(corr_enable), .setup(setup), .cmd_done(cmd_done),
    .cmd_err(cmd_err));
  tsm_host_model i_host (.clk(clk), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic close_out;
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [95:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic tsm_text_t txt(input string s);
    txt = '0;
    foreach (s[i]) txt[i] = s[i];
  endfunction
  // one line, then its completion code and reply bytes
  task automatic cmd(input logic [23:0] mn, input string a,
                     input logic [7:0] e);
    int n;
    logic [7:0] r[$];
    i_host.rq.delete();
    i_host.send(mn, a);
    n = 0;
    while (cmd_done !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk("cmd_done", cmd_done, 1'b1);
    chk("cmd_err", cmd_err, e);
    if (reply_exp && e == 8'h00)
      r = '{`TSM_CH_ACK, `TSM_CR, `TSM_LF};
    else if (reply_exp)
      r = '{`TSM_CH_E, `TSM_CH_R, `TSM_CH_R, 8'h30 + e / 8'h0a,
            8'h30 + e % 8'h0a, `TSM_CR, `TSM_LF};
    n = 0;
    while (i_host.rq.size() < r.size() && n < 40) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
    chk("reply_len", i_host.rq.size(), r.size());
    foreach (r[i]) chk("reply", i_host.rq[i], r[i]);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    inch_option = 1'b0;
    corr_enable = 1'b0;
    reply_exp = 1'b1;
    eu = 2'h0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("rst", {setup.disp_unit, setup.probe_a, setup.probe_b,
      setup.avg_count, setup.fan_on, setup.answer_on},
      {2'h0, 4'h1, 4'h1, 7'h01, 1'b1, 1'b1});
    cmd(`TSM_MN_DISP_TYPE, "1", 8'h00);
    chk("dual", setup.disp_dual, 1'b1);
    cmd(`TSM_MN_DISP_TYPE, "2", `TSM_ERR_RANGE);
    chk("dual", setup.disp_dual, 1'b1);
    cmd(`TSM_MN_DISP_TYPE, "0", 8'h00);
    chk("dual", setup.disp_dual, 1'b0);
    for (int u = 0; u < 4; u++) begin
      for (int o = 0; o < 2; o++) begin
        inch_option = o[0];
        ok = (u > 1) == (o == 1);
        ec = ok ? 8'h00 : `TSM_ERR_NOT_ALLOWED;
        cmd(`TSM_MN_DISP_UNIT, $sformatf("%0d", u), ec);
        if (ok) eu = u[1:0];
        chk("unit", setup.disp_unit, eu);
      end
    end
    cmd(`TSM_MN_SPACING, "1234.567", 8'h00);
    chk("gap", setup.sensor_gap, txt("1234.567"));
    cmd(`TSM_MN_SPACING, "123456789", `TSM_ERR_RANGE);
    chk("gap", setup.sensor_gap, txt("1234.567"));
    cmd(`TSM_MN_INS_GAP, "0.5", 8'h00);
    chk("ins", setup.ins_ref_gap, txt("0.5"));
    cmd(`TSM_MN_SPAN, "20", 8'h00);
    chk("span", setup.span, txt("20"));
    cmd(`TSM_MN_ZERO, "1.25", 8'h00);
    chk("zero", setup.zero, txt("1.25"));
    cmd(`TSM_MN_REF_PIECE, "3,1.5", 8'h00);
    chk("ref", {setup.ref_sel, setup.ref_thick}, {4'h3, txt("1.5")});
    cmd(`TSM_MN_PERMIT, "1,2.75", 8'h00);
    chk("perm", {setup.permit_sel, setup.permit}, {4'h1, txt("2.75")});
    cmd(`TSM_MN_GAP_SEL, "1", 8'h00);
    chk("gsel", setup.ins_gap_b, 1'b1);
    cmd(`TSM_MN_PROBE, "0,6", `TSM_ERR_NOT_ALLOWED);
    corr_enable = 1'b1;
    cmd(`TSM_MN_PROBE, "0,6", 8'h00);
    chk("probe_a", setup.probe_a, 4'h6);
    cmd(`TSM_MN_PROBE, "1,6", `TSM_ERR_DUP_SLOT);
    chk("probe_b", setup.probe_b, 4'h1);
    cmd(`TSM_MN_PROBE, "1,C", 8'h00);
    chk("probe_b", setup.probe_b, 4'hc);
    cmd(`TSM_MN_PROBE, "1,D", `TSM_ERR_RANGE);
    cmd(`TSM_MN_CORR_REG, "1,1,AB12,77", 8'h00);
    chk("model", setup.corr_model[0], txt("AB12"));
    chk("serial", setup.corr_serial[0], txt("77"));
    chk("chan", setup.corr_chan[0], 1'b1);
    cmd(`TSM_MN_COEFF, "2,3,-1.5", 8'h00);
    chk("coeff", setup.coeff[1][3], {32'h0, txt("-1.5")});
    cmd(`TSM_MN_AVERAGE, "64", 8'h00);
    cmd(`TSM_MN_AVERAGE, "65", `TSM_ERR_RANGE);
    cmd(`TSM_MN_AVERAGE, "0", `TSM_ERR_RANGE);
    chk("avg", setup.avg_count, 7'h40);
    cmd(`TSM_MN_AVERAGE, "1", 8'h00);
    chk("avg", setup.avg_count, 7'h01);
    i_host.slow = 1'b1;
    cmd(`TSM_MN_FAN, "2", 8'h00);
    chk("fan", setup.fan_on, 1'b0);
    cmd(`TSM_MN_FAN, "0", `TSM_ERR_RANGE);
    chk("fan", setup.fan_on, 1'b0);
    cmd(`TSM_MN_FAN, "1", 8'h00);
    chk("fan", setup.fan_on, 1'b1);
    cmd(24'h585858, "", `TSM_ERR_UNKNOWN);
    cmd(`TSM_MN_FAN, "1,1,1,1,1", `TSM_ERR_FORMAT);
    reply_exp = 1'b0;
    cmd(`TSM_MN_REPLY, "1", 8'h00);
    chk("ans", setup.answer_on, 1'b0);
    cmd(`TSM_MN_FAN, "2", 8'h00);
    reply_exp = 1'b1;
    cmd(`TSM_MN_REPLY, "0", 8'h00);
    chk("ans", setup.answer_on, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
